// >>> src/serial_vid_boot_control.v
// Purpose: Boot decode, serial voltage-code commands, slew and telemetry/alert
// Assumes: Link pins are asynchronous and far slower than the 10 MHz clock
// Notes: Link clock is sampled, not used as a clock
`timescale 1ns/1ps
`default_nettype none
`include "svid_ctrl_regs.vh"
module serial_vid_boot_control (
    // Clock, reset, enable
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire ce_in,
    // Device pins
    input wire enable_pin_in,
    input wire processor_power_ok_in,
    input wire vid_serial_clock_in,
    input wire vid_serial_data_in,
    output reg telemetry_alert_line_out,
    // Configuration
    input wire [7:0] boot_voltage_select_in,
    input wire [1:0] fast_slew_sel_in,
    input wire soft_start_quarter_in,
    // Measured current per rail, 00 to FF of full scale
    input wire [15:0] rail_current_in,
    // Rail outputs, rail 0 core, rail 1 northbridge_rail
    output wire [15:0] rail_vid_out,
    output wire [41:0] rail_uv_out,
    output reg [1:0] rail_good_output_out,
    output reg [5:0] load_line_sel_out,
    output reg [3:0] offset_sel_out,
    output reg [1:0] low_power_out,
    output reg [1:0] telemetry_mode_out,
    output reg [7:0] boot_code_out
);
    localparam ST_OFF = 3'b001;
    localparam ST_SOFT = 3'b010;
    localparam ST_RUN = 3'b100;
    localparam CMD_IDLE = 2'b01;
    localparam CMD_SHIFT = 2'b10;
    // Counts kept as integers; each use slices only the bits its register holds
    localparam integer STEP_10 = `STEP_CYC_10;
    localparam integer STEP_15 = `STEP_CYC_15;
    localparam integer STEP_20 = `STEP_CYC_20;
    localparam integer STEP_25 = `STEP_CYC_25;
    localparam integer TEL_V = `TEL_V_CYC;
    localparam integer TEL_VI = `TEL_VI_CYC;
    localparam integer TEL_LEN = `TEL_BITS;
    localparam integer PKT_LEN = `PKT_BITS;

    reg en_s1, en_s2, en_s3, pok_s1, pok_s2, pok_s3;
    reg svc_s1, svc_s2, svc_s3, svd_s1, svd_s2, svd_s3;
    reg [2:0] state_r;
    reg [1:0] cmd_r;
    reg [4:0] bit_cnt_r;
    reg [`PKT_BITS-1:0] pkt_r;
    reg [15:0] target_r;
    reg [1:0] up_pend_r;
    reg alert_pend_r;
    reg [`TEL_BITS-1:0] tel_sh_r;
    reg [4:0] tel_cnt_r;
    reg [9:0] tel_tmr_r;
    reg tel_rail_r;
    reg [7:0] fast_cyc;
    wire [1:0] done;

    wire en_rise = en_s2 & ~en_s3;
    wire pok_fall = ~pok_s2 & pok_s3;
    wire svc_rise = svc_s2 & ~svc_s3;
    wire svc_fall = ~svc_s2 & svc_s3;
    wire frm_start = svc_s2 & svc_s3 & svd_s3 & ~svd_s2;
    wire frm_stop = svc_s2 & svc_s3 & ~svd_s3 & svd_s2;
    wire cmd_ok = (cmd_r == CMD_SHIFT) && frm_stop && (bit_cnt_r == PKT_LEN[4:0])
        && pok_s2 && (state_r == ST_RUN);
    wire [7:0] pkt_vid = pkt_r[`PKT_VID_HI:`PKT_VID_LO];
    wire [2:0] pkt_ll = pkt_r[`PKT_LL_HI:`PKT_LL_LO];
    wire [1:0] pkt_ofs = pkt_r[`PKT_OFS_HI:`PKT_OFS_LO];
    wire [1:0] pkt_sel = {pkt_r[`PKT_NB_SEL], pkt_r[`PKT_VDD_SEL]};
    wire load_boot = (state_r == ST_OFF && en_rise) || (state_r != ST_OFF && pok_fall);
    wire [7:0] boot_now;
    reg [1:0] trim_chg;

    assign boot_now = boot_voltage_select_in[`BOOT_SEL_BIT] ?
        {1'b0, boot_voltage_select_in[6:0]} :
        (({svc_s2, svd_s2} == 2'b00) ? `BOOT_CODE_00 :
        ({svc_s2, svd_s2} == 2'b01) ? `BOOT_CODE_01 :
        ({svc_s2, svd_s2} == 2'b10) ? `BOOT_CODE_10 : `BOOT_CODE_11);

    always @* begin
        case (fast_slew_sel_in)
            2'h0: fast_cyc = STEP_10[7:0];
            2'h1: fast_cyc = STEP_15[7:0];
            2'h2: fast_cyc = STEP_20[7:0];
            default: fast_cyc = STEP_25[7:0];
        endcase
    end
    wire [7:0] period = (state_r == ST_SOFT) ?
        (soft_start_quarter_in ? {fast_cyc[5:0], 2'b00} : {fast_cyc[6:0], 1'b0}) : fast_cyc;

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_rail
            wire [7:0] code;
            vid_ramp u_ramp (
                .ref_clk_in(ref_clk_in),
                .sys_rst_in(sys_rst_in),
                .ce_in(ce_in),
                .target_in(target_r[8*i+7:8*i]),
                .period_in(period),
                .code_out(code),
                .uv_out(rail_uv_out[21*i+20:21*i]),
                .done_out(done[i])
            );
            assign rail_vid_out[8*i+7:8*i] = code;
            always @* begin
                trim_chg[i] = cmd_ok && pkt_sel[i] &&
                    (pkt_ll != load_line_sel_out[3*i+2:3*i] ||
                     pkt_ofs != offset_sel_out[2*i+1:2*i]);
            end
            always @(posedge ref_clk_in) begin
                if (sys_rst_in) begin
                    target_r[8*i+7:8*i] <= `VID_OFF;
                    up_pend_r[i] <= 1'b0;
                    load_line_sel_out[3*i+2:3*i] <= 3'h0;
                    offset_sel_out[2*i+1:2*i] <= 2'h0;
                end else if (ce_in) begin
                    if (!en_s2) begin
                        target_r[8*i+7:8*i] <= `VID_OFF;
                        up_pend_r[i] <= 1'b0;
                    end else if (load_boot) begin
                        target_r[8*i+7:8*i] <= (state_r == ST_OFF) ? boot_now : boot_code_out;
                        up_pend_r[i] <= 1'b0;
                        load_line_sel_out[3*i+2:3*i] <= 3'h0;
                        offset_sel_out[2*i+1:2*i] <= 2'h0;
                    end else if (cmd_ok && pkt_sel[i]) begin
                        target_r[8*i+7:8*i] <= pkt_vid;
                        up_pend_r[i] <= pkt_vid < rail_vid_out[8*i+7:8*i];
                        load_line_sel_out[3*i+2:3*i] <= pkt_ll;
                        offset_sel_out[2*i+1:2*i] <= pkt_ofs;
                    end else if (done[i]) begin
                        up_pend_r[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Upward change done, or trim changed
    wire alert_evt = (|(up_pend_r & done)) || (|trim_chg);
    wire alert_take = svc_fall && pok_s2 && (tel_cnt_r == 5'h00) && alert_pend_r;

    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            {en_s1, en_s2, en_s3, pok_s1, pok_s2, pok_s3} <= 6'h00;
            // Link lines idle high, so no false edge or frame follows reset
            {svc_s1, svc_s2, svc_s3, svd_s1, svd_s2, svd_s3} <= 6'h3F;
            state_r <= ST_OFF;
            cmd_r <= CMD_IDLE;
            bit_cnt_r <= 5'h00;
            pkt_r <= {`PKT_BITS{1'b0}};
            boot_code_out <= `BOOT_CODE_00;
            rail_good_output_out <= 2'h0;
            low_power_out <= 2'h0;
            telemetry_mode_out <= `TEL_OFF;
            alert_pend_r <= 1'b0;
            telemetry_alert_line_out <= 1'b1;
            tel_sh_r <= {`TEL_BITS{1'b1}};
            tel_cnt_r <= 5'h00;
            tel_tmr_r <= 10'h000;
            tel_rail_r <= 1'b0;
        end else if (ce_in) begin
            {en_s1, en_s2, en_s3} <= {enable_pin_in, en_s1, en_s2};
            {pok_s1, pok_s2, pok_s3} <= {processor_power_ok_in, pok_s1, pok_s2};
            {svc_s1, svc_s2, svc_s3} <= {vid_serial_clock_in, svc_s1, svc_s2};
            {svd_s1, svd_s2, svd_s3} <= {vid_serial_data_in, svd_s1, svd_s2};
            case (state_r)
                ST_OFF: begin
                    if (en_rise) begin
                        // Latch boot code once per enable
                        boot_code_out <= boot_now;
                        state_r <= ST_SOFT;
                    end
                end
                ST_SOFT: begin
                    if (&done) begin
                        rail_good_output_out <= 2'h3;
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: state_r <= ST_RUN;
                default: state_r <= ST_OFF;
            endcase
            if (!en_s2) begin
                state_r <= ST_OFF;
                rail_good_output_out <= 2'h0;
            end
            // Frames framed by processor clock and data
            case (cmd_r)
                CMD_IDLE: begin
                    if (frm_start && pok_s2) begin
                        cmd_r <= CMD_SHIFT;
                        bit_cnt_r <= 5'h00;
                    end
                end
                CMD_SHIFT: begin
                    if (frm_stop || frm_start)
                        cmd_r <= frm_start ? CMD_SHIFT : CMD_IDLE;
                    if (frm_start)
                        bit_cnt_r <= 5'h00;
                    else if (svc_rise && bit_cnt_r != 5'h1F) begin
                        pkt_r <= {pkt_r[`PKT_BITS-2:0], svd_s2};
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                    end
                end
                default: cmd_r <= CMD_IDLE;
            endcase
            if (cmd_ok) begin
                low_power_out <= ~{pkt_r[`PKT_PSI1_L], pkt_r[`PKT_PSI0_L]};
                if (pkt_r[`PKT_TFN])
                    telemetry_mode_out <= pkt_sel;
            end
            // Set wins over take, so a simultaneous event is not lost
            alert_pend_r <= (alert_pend_r & ~alert_take) | alert_evt;
            if (telemetry_mode_out == `TEL_VONLY || telemetry_mode_out == `TEL_VCUR) begin
                if (tel_tmr_r + 10'h001 >= ((telemetry_mode_out == `TEL_VONLY) ?
                        TEL_V[9:0] : TEL_VI[9:0])) begin
                    tel_tmr_r <= 10'h000;
                    if (tel_cnt_r == 5'h00) begin
                        tel_cnt_r <= TEL_LEN[4:0];
                        tel_rail_r <= ~tel_rail_r;
                        // Voltage pair, or one rail's voltage and current
                        tel_sh_r <= (telemetry_mode_out == `TEL_VONLY) ?
                            {1'b0, rail_vid_out[7:0], rail_vid_out[15:8]} :
                            (tel_rail_r ? {1'b0, rail_vid_out[15:8], rail_current_in[15:8]} :
                             {1'b0, rail_vid_out[7:0], rail_current_in[7:0]});
                    end
                end else begin
                    tel_tmr_r <= tel_tmr_r + 10'h001;
                end
            end else begin
                tel_tmr_r <= 10'h000;
            end
            if (!pok_s2 || load_boot) begin
                // Command logic reset, line idles high
                cmd_r <= CMD_IDLE;
                bit_cnt_r <= 5'h00;
                tel_cnt_r <= 5'h00;
                telemetry_alert_line_out <= 1'b1;
            end else if (svc_fall) begin
                if (tel_cnt_r != 5'h00) begin
                    telemetry_alert_line_out <= tel_sh_r[`TEL_BITS-1];
                    tel_sh_r <= {tel_sh_r[`TEL_BITS-2:0], 1'b1};
                    tel_cnt_r <= tel_cnt_r - 5'h01;
                end else begin
                    // Alert holds the line low for one link clock period
                    telemetry_alert_line_out <= ~alert_pend_r;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> pkg/svid_ctrl_regs.vh
// Purpose: Constants for the serial voltage-code boot and command control
// Assumes: 10 MHz reference clock; all codes are 8-bit voltage codes
// Notes: Packet layout and timing counts are used by the control design only; the ramp uses the code constants
`ifndef SVID_CTRL_REGS_VH
`define SVID_CTRL_REGS_VH

`define REF_CLK_MHZ 10
`define BOOT_SEL_BIT 7
`define BOOT_CODE_00 8'h48
`define BOOT_CODE_01 8'h58
`define BOOT_CODE_10 8'h68
`define BOOT_CODE_11 8'h78
`define VID_OFF 8'hF8
`define UV_AT_ZERO 1550000
`define UV_PER_CODE 6250
// One code step is 6.25 mV; time per step at each fast rate, in ns
`define STEP_NS_10 625
`define STEP_NS_15 417
`define STEP_NS_20 313
`define STEP_NS_25 250
`define STEP_CYC_10 (`STEP_NS_10 * `REF_CLK_MHZ / 1000)
`define STEP_CYC_15 (`STEP_NS_15 * `REF_CLK_MHZ / 1000)
`define STEP_CYC_20 (`STEP_NS_20 * `REF_CLK_MHZ / 1000)
`define STEP_CYC_25 (`STEP_NS_25 * `REF_CLK_MHZ / 1000)
`define TEL_V_HZ 20000
`define TEL_VI_HZ 40000
`define TEL_V_CYC (`REF_CLK_MHZ * 1000000 / `TEL_V_HZ)
`define TEL_VI_CYC (`REF_CLK_MHZ * 1000000 / `TEL_VI_HZ)
`define TEL_BITS 17
// Command packet, MSB first, 20 bits
`define PKT_BITS 20
`define PKT_VDD_SEL 19
`define PKT_NB_SEL 18
`define PKT_PSI0_L 17
`define PKT_VID_HI 16
`define PKT_VID_LO 9
`define PKT_PSI1_L 8
`define PKT_TFN 7
`define PKT_LL_HI 6
`define PKT_LL_LO 4
`define PKT_OFS_HI 3
`define PKT_OFS_LO 2
`define TEL_VONLY 2'h0
`define TEL_VCUR 2'h1
`define TEL_OFF 2'h2

`endif

// >>> src/vid_ramp.v
// Purpose: Steps one rail's voltage code toward its target
// Assumes: period_in is at least one cycle
// Notes: Lower code means higher voltage
`timescale 1ns/1ps
`default_nettype none
`include "svid_ctrl_regs.vh"
module vid_ramp (
    // Clock and reset
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire ce_in,
    // Control
    input wire [7:0] target_in,
    input wire [7:0] period_in,
    // Status
    output reg [7:0] code_out,
    output reg [20:0] uv_out,
    output wire done_out
);
    reg [7:0] cnt_r;
    localparam integer UV_ZERO = `UV_AT_ZERO;
    // Full-width product; the top of the code range still fits in 21 bits
    wire [31:0] prod = `UV_PER_CODE * code_out;

    assign done_out = (code_out == target_in);

    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            code_out <= `VID_OFF;
            cnt_r <= 8'h00;
            uv_out <= 21'h000000;
        end else if (ce_in) begin
            if (done_out) begin
                cnt_r <= 8'h00;
            end else if (cnt_r + 8'h01 >= period_in) begin
                cnt_r <= 8'h00;
                code_out <= (target_in < code_out) ? code_out - 8'h01 : code_out + 8'h01;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
            if (code_out >= `VID_OFF)
                uv_out <= 21'h000000;
            else
                uv_out <= UV_ZERO[20:0] - prod[20:0];
        end
    end
endmodule
`default_nettype wire

// >>> tb/svid_ctrl_sva.sv
// Purpose: Port-level checks of the voltage-code controller
// Assumes: ce_in held high while checks matter
// Notes: Enable history kept locally since the pin is synchronised inside
`timescale 1ns/1ps
`default_nettype none
module svid_ctrl_sva (
    // Clock and reset
    input wire ref_clk_in,
    input wire sys_rst_in,
    // Watched ports
    input wire enable_pin_in,
    input wire processor_power_ok_in,
    input wire telemetry_alert_line_out,
    input wire [15:0] rail_vid_out,
    input wire [41:0] rail_uv_out,
    input wire [1:0] rail_good_output_out,
    input wire [5:0] load_line_sel_out,
    input wire [3:0] offset_sel_out,
    input wire [1:0] low_power_out,
    input wire [1:0] telemetry_mode_out,
    input wire [7:0] boot_code_out
);
    // Enable seen high long enough to pass the synchroniser
    reg [5:0] en_q_r;
    wire en_ok = &en_q_r;
    always @(posedge ref_clk_in) begin
        en_q_r <= {en_q_r[4:0], enable_pin_in};
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_uv_from_code:
    assert property (rail_uv_out[20:0] == ($past(rail_vid_out[7:0]) < 8'hF8 ?
        21'h17A6B0 - 21'h186A * $past(rail_vid_out[7:0]) : 21'h0))
        else $error("rail0 microvolts do not match code");
    a_single_step:
    assert property (en_ok && $changed(rail_vid_out[7:0]) |->
        (rail_vid_out[7:0] - $past(rail_vid_out[7:0]) == 8'h01 ||
        $past(rail_vid_out[7:0]) - rail_vid_out[7:0] == 8'h01) ##1 $stable(rail_vid_out[7:0]))
        else $error("rail0 code moved by more than one step");
    a_good_at_boot:
    assert property ($rose(rail_good_output_out[0]) |-> rail_vid_out[7:0] == boot_code_out)
        else $error("rail good before boot code reached");
    a_boot_held:
    assert property (en_ok |=> $stable(boot_code_out))
        else $error("boot code changed while enabled");
    a_alert_idle_pok:
    assert property (!processor_power_ok_in [*5] |-> telemetry_alert_line_out)
        else $error("telemetry line low with power-ok low");
    a_trims_cleared:
    assert property (!processor_power_ok_in [*5] |-> load_line_sel_out == 6'h00 &&
        offset_sel_out == 4'h0) else $error("trims kept after power-ok fall");
    a_ignore_pok_low:
    assert property (!processor_power_ok_in [*5] |=> $stable(low_power_out) &&
        $stable(telemetry_mode_out)) else $error("command taken with power-ok low");
    a_good_off_en:
    assert property (!enable_pin_in [*4] |-> rail_good_output_out == 2'h0)
        else $error("rail good while disabled");
endmodule
bind serial_vid_boot_control svid_ctrl_sva chk_i (.ref_clk_in, .sys_rst_in, .enable_pin_in,
    .processor_power_ok_in, .telemetry_alert_line_out, .rail_vid_out, .rail_uv_out,
    .rail_good_output_out, .load_line_sel_out, .offset_sel_out, .low_power_out,
    .telemetry_mode_out, .boot_code_out);
`default_nettype wire

// >>> tb/svid_host_model.sv
// Purpose: Processor side of the serial voltage-code link
// Assumes: Link period 800 ns, clock and data idle high
// Notes: Clock stands still between frames; alert sampled on clock rise
`timescale 1ns/1ps
`default_nettype none
module svid_host_model (
    // Link pins
    output logic clk_out,
    output logic dat_out,
    input wire logic alert_in,
    // Observation
    output logic saw_low_out,
    output logic [18:0] rx_out
);
    initial begin
        clk_out = 1'b1;
        dat_out = 1'b1;
        saw_low_out = 1'b0;
        rx_out = 19'h00000;
    end
    task automatic set_lines(input logic c, input logic d);
        clk_out = c;
        dat_out = d;
    endtask
    task automatic frame(input logic [19:0] pkt, input int n);
        int i;
        #37;
        saw_low_out = 1'b0;
        dat_out = 1'b0;
        #400;
        for (i = 19; i > 19 - n; i--) begin
            clk_out = 1'b0;
            dat_out = pkt[i];
            #400;
            clk_out = 1'b1;
            rx_out = {rx_out[17:0], alert_in};
            if (alert_in === 1'b0)
                saw_low_out = 1'b1;
            #400;
        end
        // Packets end on a low bit, so data rises as stop with no extra clock
        dat_out = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the voltage-code controller
// Assumes: Host model drives the link; ce_in held high
// Notes: Ramp gaps measured on a later step, the first may precede frame end
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic en = 1'b0;
    logic pok = 1'b0;
    logic quarter = 1'b0;
    logic [7:0] bsel = 8'h00;
    logic [1:0] slew = 2'h3;
    wire vid_serial_clock, vid_serial_data, line, saw;
    wire [18:0] rx;
    wire [15:0] vid;
    wire [41:0] uv;
    wire [1:0] good, lp, mode;
    wire [5:0] ll;
    wire [3:0] ofs;
    wire [7:0] boot;
    int fail_count = 0;
    int checks = 0;
    always #50 ref_clk_in = ~ref_clk_in;
    svid_host_model host (.clk_out(vid_serial_clock), .dat_out(vid_serial_data), .alert_in(line), .saw_low_out(saw),
        .rx_out(rx));
    serial_vid_boot_control dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .ce_in(1'b1), .enable_pin_in(en), .processor_power_ok_in(pok),
        .vid_serial_clock_in(vid_serial_clock), .vid_serial_data_in(vid_serial_data), .telemetry_alert_line_out(line),
        .boot_voltage_select_in(bsel), .fast_slew_sel_in(slew), .soft_start_quarter_in(quarter),
        .rail_current_in(16'h3C5A), .rail_vid_out(vid), .rail_uv_out(uv),
        .rail_good_output_out(good), .load_line_sel_out(ll), .offset_sel_out(ofs),
        .low_power_out(lp), .telemetry_mode_out(mode), .boot_code_out(boot));
    task automatic close_out();
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [41:0] got, input logic [41:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    function automatic logic [7:0] val(input int w);
        return w == 2 ? {6'h00, good} : vid[w*8 +: 8];
    endfunction
    task automatic wait_for(input int w, input logic [7:0] c);
        int i;
        for (i = 0; i < 3000 && val(w) !== c; i++)
            cyc(1);
        if (i == 3000) begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic step_gap(input logic [7:0] c, input int e);
        int n;
        wait_for(0, c);
        for (n = 0; n < 20 && vid[7:0] === c; n++)
            cyc(1);
        chk(n, e);
    endtask
    function automatic logic [19:0] pkt(input logic [1:0] sel, input logic [7:0] c,
        input logic [1:0] psil, input logic tfn, input logic [2:0] l, input logic [1:0] o);
        return {sel[0], sel[1], psil[0], c, psil[1], tfn, l, o, 2'b00};
    endfunction
    task automatic t_boot();
        int k;
        for (k = 0; k < 4; k++) begin
            en = 1'b0;
            host.set_lines(k[1], k[0]);
            cyc(4);
            en = 1'b1;
            cyc(6);
            chk(boot, 8'h48 + 8'h10 * k);
        end
        host.set_lines(1'b1, 1'b1);
        wait_for(2, 8'h03);
        chk(vid, 16'h7878);
    endtask
    task automatic t_boot_reg();
        en = 1'b0;
        bsel = 8'hA5;
        quarter = 1'b1;
        wait_for(0, 8'hF8);
        en = 1'b1;
        cyc(6);
        chk(boot, 8'h25);
        bsel = 8'h00;
        step_gap(8'hF7, 8);
        chk(boot, 8'h25);
        wait_for(2, 8'h03);
    endtask
    task automatic t_cmds();
        int s;
        pok = 1'b1;
        cyc(4);
        for (s = 0; s < 3; s++) begin
            host.frame(pkt(s[1:0], 8'h25, 2'h3, 1'b1, 3'h0, 2'h0), 20);
            cyc(8);
            chk(mode, s[1:0]);
        end
        host.frame(pkt(2'h1, 8'h25, 2'h0, 1'b0, 3'h5, 2'h1), 20);
        cyc(8);
        chk({ll, ofs, lp}, {6'h05, 4'h1, 2'h3});
        host.frame(20'h00000, 19);
        chk(saw, 1'b1);
        host.frame(pkt(2'h1, 8'h20, 2'h3, 1'b0, 3'h5, 2'h1), 20);
        wait_for(0, 8'h20);
        chk(vid[15:8], 8'h25);
        host.frame(20'h00000, 19);
        chk(saw, 1'b1);
    endtask
    task automatic t_slew();
        int s;
        int per[4] = '{6, 4, 3, 2};
        for (s = 0; s < 4; s++) begin
            slew = s[1:0];
            host.frame(pkt(2'h1, 8'h28 + 8'h08 * s, 2'h3, 1'b0, 3'h5, 2'h1), 20);
            step_gap(8'h23 + 8'h08 * s, per[s]);
            wait_for(0, 8'h28 + 8'h08 * s);
        end
    endtask
    task automatic t_pok();
        pok = 1'b0;
        wait_for(0, 8'h25);
        chk({line, ll, ofs}, {1'b1, 6'h00, 4'h0});
        host.frame(pkt(2'h3, 8'h50, 2'h3, 1'b0, 3'h2, 2'h2), 20);
        cyc(50);
        chk(vid, 16'h2525);
        pok = 1'b1;
        cyc(4);
        chk(boot, 8'h25);
        host.frame(pkt(2'h3, 8'h50, 2'h3, 1'b0, 3'h2, 2'h2), 19);
        cyc(50);
        chk(vid, 16'h2525);
        chk(uv, {2{21'h141F5E}});
        host.frame(pkt(2'h0, 8'h25, 2'h3, 1'b1, 3'h0, 2'h0), 20);
        cyc(520);
        host.frame(20'h00000, 19);
        chk(rx, {1'b0, 8'h25, 8'h25, 2'h3});
    endtask
    initial begin
        cyc(2);
        sys_rst_in = 1'b0;
        t_boot();
        t_boot_reg();
        t_cmds();
        t_slew();
        t_pok();
        close_out();
    end
endmodule
`default_nettype wire
